/* File: pkg/sensor_port_pkg.sv */
package sensor_port_pkg;

  // I2C address, upper six bits; low bit is the inverse of chip select
  localparam logic [5:0] I2C_ADDR_HI = 6'h3B;

  // Command bytes
  localparam logic [7:0] CMD_RESET = 8'h1E;
  localparam logic [7:0] CMD_ADC_READ = 8'h00;
  localparam logic [7:0] CMD_CONV_PRESS = 8'h40;
  localparam logic [7:0] CMD_CONV_TEMP = 8'h50;
  localparam logic [7:0] CMD_PROM_READ = 8'hA0;

  // Command field positions
  localparam int CONVERT_FLAG_BIT = 6;
  localparam int PROM_FLAG_BIT = 7;
  localparam int TYPE_BIT = 4;
  localparam int IDX_LSB = 1;
  localparam int IDX_MSB = 3;

  // PROM word offsets
  localparam logic [2:0] FACTORY_SETUP_WORD = 3'h0;
  localparam logic [2:0] CALIB_WORD_1 = 3'h1;
  localparam logic [2:0] CALIB_WORD_6 = 3'h6;
  localparam logic [2:0] SERIAL_AND_CHECK_WORD = 3'h7;
  localparam int PROM_WORDS = 8;
  localparam int PROM_WIDTH = 16;
  localparam int CRC_WIDTH = 4;
  localparam int RESULT_WIDTH = 24;

  // Conversion times in microseconds per oversampling ratio, 256 up to 4096
  localparam int CLK_MHZ = 50;
  localparam int CONV_US_256 = 600;
  localparam int CONV_US_512 = 1170;
  localparam int CONV_US_1024 = 2280;
  localparam int CONV_US_2048 = 4540;
  localparam int CONV_US_4096 = 9040;
  localparam int CONV_CYC_256 = CONV_US_256 * CLK_MHZ;
  localparam int CONV_CYC_512 = CONV_US_512 * CLK_MHZ;
  localparam int CONV_CYC_1024 = CONV_US_1024 * CLK_MHZ;
  localparam int CONV_CYC_2048 = CONV_US_2048 * CLK_MHZ;
  localparam int CONV_CYC_4096 = CONV_US_4096 * CLK_MHZ;

  // PROM load takes one cycle per word after one cycle of read latency
  localparam logic [3:0] LOAD_DONE = 4'h9;

  // Arbitrary default PROM contents, factory programmed in silicon
  localparam logic [127:0] PROM_DEFAULT = 128'h4000_1234_5678_9ABC_DEF0_1357_2468_0ACE;

  typedef struct packed {
    logic clk;
    logic din;
    logic cs_n;
  } serial_pins_t;

  typedef struct packed {
    logic valid;
    logic press;
    logic [2:0] oversampling_ratio;
  } conv_req_t;

endpackage : sensor_port_pkg

/* File: hw/prom_store.sv */
`timescale 1ns/100ps
module prom_store
  import sensor_port_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Read port
  input wire logic [2:0] i_addr,
  output logic [PROM_WIDTH-1:0] o_data
);

  logic [PROM_WIDTH-1:0] mem [PROM_WORDS];

  // Factory content, word 0 setup, 1 to 6 coefficients, 7 serial and CRC
  for (genvar g = 0; g < PROM_WORDS; g++) begin : g_word
    assign mem[g] = PROM_DEFAULT[(PROM_WORDS-1-g)*PROM_WIDTH +: PROM_WIDTH];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data <= 16'h0000;
    end else begin
      o_data <= mem[i_addr];
    end
  end

endmodule : prom_store

/* File: hw/sensor_serial_command_port.sv */
`timescale 1ns/100ps
module sensor_serial_command_port
  import sensor_port_pkg::*;
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  // Serial pins
  input wire logic I_PROTOCOL_SELECT,
  input wire logic I_CHIP_SELECT_N,
  input wire logic I_SCLK,
  input wire logic I_SERIAL_IN,
  // Outputs
  output logic O_SERIAL_OUT,
  output logic O_SDA_OE,
  output logic O_BUSY,
  // Converter values
  input wire logic [RESULT_WIDTH-1:0] I_RAW_PRESSURE_VALUE,
  input wire logic [RESULT_WIDTH-1:0] I_RAW_TEMPERATURE_VALUE
);

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CMD, S_TX, S_ACK_TX, S_ACK_RX, S_SKIP} bus_t;

  serial_pins_t s1_q, s2_q, s3_q;
  logic ps1_q, ps_q;
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      ps1_q <= 1'b0;
      ps_q <= 1'b0;
    end else begin
      s1_q <= '{I_SCLK, I_SERIAL_IN, I_CHIP_SELECT_N};
      s2_q <= s1_q;
      s3_q <= s2_q;
      ps1_q <= I_PROTOCOL_SELECT;
      ps_q <= ps1_q;
    end
  end

  logic i2c_mode;
  assign i2c_mode = ps_q;
  logic rise, fall, start_c, stop_c, cs_rise, cs_fall;
  assign rise = s2_q.clk & ~s3_q.clk;
  assign fall = ~s2_q.clk & s3_q.clk;
  assign start_c = i2c_mode & s2_q.clk & s3_q.clk & s3_q.din & ~s2_q.din;
  assign stop_c = i2c_mode & s2_q.clk & s3_q.clk & ~s3_q.din & s2_q.din;
  assign cs_fall = ~i2c_mode & ~s2_q.cs_n & s3_q.cs_n;
  assign cs_rise = ~i2c_mode & s2_q.cs_n & ~s3_q.cs_n;

  bus_t st_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic [23:0] tx_q;
  logic [4:0] tx_left_q;
  logic cmd_stb;
  logic [7:0] cmd_byte;
  logic read_dir_q;
  logic sda_q;
  logic rdy_q;
  logic [23:0] result_q;
  logic prom_mode_q;
  logic [2:0] idx_q;
  logic [PROM_WIDTH-1:0] prom_rd;
  logic [PROM_WIDTH-1:0] shadow_q [PROM_WORDS];
  logic [3:0] load_q;

  // Command decode
  logic is_reset, is_read, is_conv, is_prom;
  assign cmd_byte = {sh_q[6:0], s2_q.din};
  assign is_reset = cmd_byte == CMD_RESET;
  assign is_read = cmd_byte == CMD_ADC_READ;
  assign is_conv = cmd_byte[CONVERT_FLAG_BIT] && !cmd_byte[PROM_FLAG_BIT] &&
                   !cmd_byte[0] && cmd_byte[3:1] <= 3'h4 &&
                   (cmd_byte & 8'hA0) == 8'h00;
  assign is_prom = (cmd_byte & 8'hF1) == CMD_PROM_READ;
  logic addr_hit;
  assign addr_hit = sh_q[7:2] == I2C_ADDR_HI && sh_q[1] == ~s2_q.cs_n;

  // Serial front end, shared by both protocols
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_q <= S_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      read_dir_q <= 1'b0;
      sda_q <= 1'b0;
      tx_left_q <= 5'h00;
    end else if (start_c) begin
      st_q <= S_ADDR;
      bit_q <= 4'h0;
      sda_q <= 1'b0;
    end else if (stop_c || cs_rise) begin
      st_q <= S_IDLE;
      sda_q <= 1'b0;
    end else if (cs_fall) begin
      st_q <= S_CMD;
      bit_q <= 4'h0;
    end else if (rise) begin
      unique case (st_q)
        S_ADDR, S_CMD: begin
          sh_q <= cmd_byte;
          bit_q <= bit_q + 4'h1;
          if (bit_q == 4'h7) begin
            // Count of eight marks a whole byte for the next falling edge
            bit_q <= 4'h8;
            if (st_q == S_ADDR) begin
              read_dir_q <= s2_q.din;
            end
          end
        end
        S_ACK_RX: begin
          bit_q <= 4'h0;
          if (s2_q.din) begin
            st_q <= S_SKIP;
          end
        end
        S_TX: bit_q <= bit_q + 4'h1;
        default: ;
      endcase
    end else if (fall) begin
      unique case (st_q)
        S_ADDR: begin
          if (bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (addr_hit) begin
              st_q <= S_ACK_TX;
              sda_q <= 1'b1;
            end else begin
              st_q <= S_SKIP;
            end
          end
        end
        S_CMD: begin
          if (bit_q == 4'h8 && i2c_mode) begin
            bit_q <= 4'h0;
            st_q <= S_ACK_TX;
            sda_q <= 1'b1;
            read_dir_q <= 1'b0;
          end else if (bit_q == 4'h8) begin
            bit_q <= 4'h0;
            st_q <= S_TX;
          end
        end
        S_ACK_TX: begin
          if (read_dir_q) begin
            st_q <= S_TX;
            sda_q <= ~tx_q[23];
          end else begin
            st_q <= S_CMD;
            sda_q <= 1'b0;
          end
        end
        S_TX: begin
          if (i2c_mode && bit_q == 4'h8) begin
            st_q <= S_ACK_RX;
            sda_q <= 1'b0;
          end else if (i2c_mode) begin
            // Line shows the bit that this edge's shift brings up
            sda_q <= ~tx_q[22];
          end
        end
        S_ACK_RX: sda_q <= ~tx_q[22];
        default: ;
      endcase
      if (st_q == S_ACK_RX) begin
        st_q <= S_TX;
      end
    end
  end

  // Command strobe on the eighth bit of a command byte
  assign cmd_stb = rise && st_q == S_CMD && bit_q == 4'h7 && !start_c && !stop_c;

  // Transmit shifter, MSB first
  logic load_tx;
  assign load_tx = (fall && st_q == S_ADDR && bit_q == 4'h8 && sh_q[0] && addr_hit) ||
                   (cmd_stb && !i2c_mode);
  logic [23:0] tx_src;
  assign tx_src = prom_mode_q ? {shadow_q[idx_q], 8'h00} : (rdy_q ? result_q : 24'h00_0000);
  logic [23:0] spi_src;
  assign spi_src = is_prom ? {shadow_q[cmd_byte[IDX_MSB:IDX_LSB]], 8'h00} : 24'h00_0000;
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tx_q <= 24'h00_0000;
    end else if (load_tx && i2c_mode) begin
      tx_q <= tx_src;
    end else if (load_tx) begin
      tx_q <= is_read ? (rdy_q ? result_q : 24'h00_0000) : spi_src;
    end else if (fall && st_q == S_TX && !(i2c_mode && bit_q == 4'h8)) begin
      tx_q <= {tx_q[22:0], 1'b0};
    end else if (fall && st_q == S_ACK_RX) begin
      tx_q <= {tx_q[22:0], 1'b0};
    end
  end

  // Conversion engine
  conv_req_t conv_q;
  logic [31:0] cnt_q;
  logic corrupt_q;
  logic [31:0] conv_len;
  always_comb begin
    unique case (cmd_byte[3:1])
      3'h0: conv_len = CONV_CYC_256;
      3'h1: conv_len = CONV_CYC_512;
      3'h2: conv_len = CONV_CYC_1024;
      3'h3: conv_len = CONV_CYC_2048;
      default: conv_len = CONV_CYC_4096;
    endcase
  end
  logic take_read;
  assign take_read = i2c_mode ? load_tx && !prom_mode_q : cmd_stb && is_read;
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      conv_q <= '0;
      cnt_q <= 32'h0000_0000;
      corrupt_q <= 1'b0;
      rdy_q <= 1'b0;
      result_q <= 24'h00_0000;
      prom_mode_q <= 1'b0;
      idx_q <= 3'h0;
    end else if (cmd_stb && is_reset) begin
      conv_q <= '0;
      cnt_q <= 32'h0000_0000;
      corrupt_q <= 1'b0;
      rdy_q <= 1'b0;
      prom_mode_q <= 1'b0;
    end else begin
      if (cmd_stb && is_conv) begin
        corrupt_q <= conv_q.valid;
        conv_q <= '{1'b1, ~cmd_byte[TYPE_BIT], cmd_byte[3:1]};
        cnt_q <= conv_len;
        rdy_q <= 1'b0;
      end else if (conv_q.valid && cnt_q > 32'h0000_0001) begin
        cnt_q <= cnt_q - 32'h0000_0001;
      end else if (conv_q.valid) begin
        conv_q.valid <= 1'b0;
        rdy_q <= 1'b1;
        result_q <= corrupt_q ? ~(conv_q.press ? I_RAW_PRESSURE_VALUE : I_RAW_TEMPERATURE_VALUE)
                              : (conv_q.press ? I_RAW_PRESSURE_VALUE : I_RAW_TEMPERATURE_VALUE);
      end
      if (take_read && conv_q.valid) begin
        corrupt_q <= 1'b1;
      end else if (take_read) begin
        rdy_q <= 1'b0;
      end
      if (cmd_stb && is_prom) begin
        prom_mode_q <= 1'b1;
        idx_q <= cmd_byte[IDX_MSB:IDX_LSB];
      end else if (cmd_stb && is_read) begin
        prom_mode_q <= 1'b0;
      end
    end
  end

  // PROM shadow load after reset command
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      load_q <= LOAD_DONE;
    end else if (cmd_stb && is_reset) begin
      load_q <= 4'h0;
    end else if (load_q != LOAD_DONE) begin
      load_q <= load_q + 4'h1;
    end
  end
  for (genvar w = 0; w < PROM_WORDS; w++) begin : g_shadow
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
        shadow_q[w] <= 16'h0000;
      end else if (load_q == 4'(w + 1)) begin
        shadow_q[w] <= prom_rd;
      end
    end
  end

  prom_store u_prom (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RSTN),
    .i_addr(load_q[2:0]),
    .o_data(prom_rd)
  );

  // Outputs
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_SERIAL_OUT <= 1'b0;
    end else begin
      O_SERIAL_OUT <= tx_q[23];
    end
  end
  assign O_SDA_OE = i2c_mode & sda_q;
  assign O_BUSY = conv_q.valid;

  a_busy_holds: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    $rose(conv_q.valid) |-> conv_q.valid [*8])
    else $error("conversion ended too early");
  a_reset_idle: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    cmd_stb && is_reset |=> !conv_q.valid && !rdy_q)
    else $error("reset command did not clear state");
  a_read_zero: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    take_read && !rdy_q && !prom_mode_q |=> tx_q == 24'h00_0000)
    else $error("stale result not zero");
  a_conv_type: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    cmd_stb && is_conv && !is_reset |=> conv_q.press == ~$past(cmd_byte[TYPE_BIT]))
    else $error("wrong conversion type");
  a_prom_idx: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    cmd_stb && is_prom |=> prom_mode_q && idx_q == $past(cmd_byte[3:1]))
    else $error("PROM index wrong");
  a_read_no_abort: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    take_read && conv_q.valid && cnt_q > 32'h0000_0002 |=> conv_q.valid && corrupt_q)
    else $error("read aborted conversion");
  a_prom_load: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    cmd_stb && is_reset |-> ##[1:12] load_q == LOAD_DONE)
    else $error("PROM load stalled");
  a_sda_mode: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    !i2c_mode |-> !O_SDA_OE)
    else $error("SDA driven in SPI mode");
  c_conv: cover property (@(posedge I_CORE_CLK) $fell(conv_q.valid));
  c_prom: cover property (@(posedge I_CORE_CLK) cmd_stb && is_prom);
  c_addr_ack: cover property (@(posedge I_CORE_CLK) st_q == S_ACK_TX && read_dir_q);

endmodule : sensor_serial_command_port

/* File: testbench/host_model.sv */
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic i_clk,
  // Device pins
  input wire logic i_serial_out,
  input wire logic i_sda_oe,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din
);
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic din = 1'b1;
  assign o_sclk = sclk;
  assign o_cs_n = cs_n;
  // Data line with pull-up, pulled low by either party
  assign o_din = din & ~i_sda_oe;

  // Half link period, 160 ns link clock
  task automatic hp;
    repeat (4) @(posedge i_clk);
    #1;
  endtask : hp

  // SPI frame: command byte, then nrd bits read back
  task automatic spi(input logic m3, input logic [7:0] cmd, input int nrd,
                     output logic [23:0] rd);
    rd = '0;
    sclk = m3;
    cs_n = 1'b0;
    hp();
    for (int i = 0; i < 8 + nrd; i++) begin
      sclk = 1'b0;
      din = (i < 8) ? cmd[7-i] : ~din;
      hp();
      if (i >= 8) rd = {rd[22:0], i_serial_out};
      sclk = 1'b1;
      hp();
    end
    sclk = m3;
    hp();
    cs_n = 1'b1;
    din = ~din;
    hp();
  endtask : spi

  task automatic i2c_bit(input logic b, output logic s);
    hp();
    din = b;
    hp();
    sclk = 1'b1;
    hp();
    s = o_din;
    sclk = 1'b0;
  endtask : i2c_bit

  task automatic i2c_start;
    hp();
    din = 1'b1;
    hp();
    sclk = 1'b1;
    hp();
    din = 1'b0;
    hp();
    sclk = 1'b0;
  endtask : i2c_start

  task automatic i2c_stop;
    hp();
    din = 1'b0;
    hp();
    sclk = 1'b1;
    hp();
    din = 1'b1;
    hp();
  endtask : i2c_stop

  // Byte plus acknowledge slot, slot level in r[0]
  task automatic i2c_byte(input logic [7:0] w, input logic ack, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) i2c_bit((i > 0) ? w[i-1] : ack, r[i]);
  endtask : i2c_byte

  // Whole transaction; a write sends one command byte
  task automatic i2c_xfer(input logic [6:0] a, input logic rw, input logic [7:0] cmd,
                          input int nrd, output logic [23:0] rd, output logic ackd);
    logic [8:0] r;
    i2c_start();
    i2c_byte({a, rw}, 1'b1, r);
    ackd = ~r[0];
    rd = '0;
    if (!rw) i2c_byte(cmd, 1'b1, r);
    for (int i = 0; i < nrd; i++) begin
      i2c_byte(8'hFF, (i == nrd - 1), r);
      rd = {rd[15:0], r[8:1]};
    end
    i2c_stop();
  endtask : i2c_xfer
endmodule : host_model

/* File: testbench/tb_sensor_serial_command_port.sv */
`timescale 1ns/100ps
module tb_sensor_serial_command_port;
  import sensor_port_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic sclk, cs_n, din, dout, sda_oe, busy, ak, s0;
  logic [23:0] rd;
  logic [23:0] raw_p = 24'hA5_C396;
  logic [23:0] raw_t = 24'h3C_5AE1;
  logic [6:0] adr;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;

  sensor_serial_command_port dut (
    .I_CORE_CLK(clk), .I_RSTN(rst_n), .I_PROTOCOL_SELECT(psel),
    .I_CHIP_SELECT_N(cs_n), .I_SCLK(sclk), .I_SERIAL_IN(din),
    .O_SERIAL_OUT(dout), .O_SDA_OE(sda_oe), .O_BUSY(busy),
    .I_RAW_PRESSURE_VALUE(raw_p), .I_RAW_TEMPERATURE_VALUE(raw_t)
  );

  host_model host (
    .i_clk(clk), .i_serial_out(dout), .i_sda_oe(sda_oe),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din)
  );

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_busy(input logic lvl, input int lim);
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_busy

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    host.spi(1'b0, CMD_RESET, 0, rd);
    repeat (20) @(posedge clk);
    #1;
    for (int w = 0; w < PROM_WORDS; w++) begin
      host.spi(w[0], CMD_PROM_READ | 8'(w << IDX_LSB), 16, rd);
      chk(rd, {8'h00, PROM_DEFAULT[16*(7-w) +: 16]});
    end
    // Every conversion code starts, then a reset stops it
    for (int k = 0; k < 10; k++) begin
      host.spi(k[0], (k < 5 ? CMD_CONV_PRESS : CMD_CONV_TEMP) | 8'(2 * (k % 5)), 0, rd);
      chk(24'(busy), 24'h1);
      host.spi(k[0], CMD_RESET, 0, rd);
      wait_busy(1'b0, 20);
      chk(24'(busy), 24'h0);
    end
    host.spi(1'b1, CMD_ADC_READ, 24, rd);
    chk(rd, 24'h0);
    host.spi(1'b0, CMD_CONV_PRESS, 0, rd);
    wait_busy(1'b0, 31000);
    chk(24'(n > CONV_CYC_256 - 30 && n < CONV_CYC_256 + 3), 24'h1);
    host.spi(1'b1, CMD_ADC_READ, 24, rd);
    chk(rd, raw_p);
    host.spi(1'b0, CMD_ADC_READ, 24, rd);
    chk(rd, 24'h0);
    host.spi(1'b1, CMD_CONV_TEMP, 0, rd);
    repeat (100) @(posedge clk);
    #1;
    host.spi(1'b0, CMD_ADC_READ, 24, rd);
    chk(rd, 24'h0);
    chk(24'(busy), 24'h1);
    wait_busy(1'b0, 31000);
    host.spi(1'b0, CMD_ADC_READ, 24, rd);
    chk(rd, ~raw_t);
    // Two-wire mode, chip select high gives address LSB 0
    psel = 1'b1;
    adr = {I2C_ADDR_HI, 1'b0};
    repeat (10) @(posedge clk);
    #1;
    for (int i = 0; i < 9; i++) host.i2c_bit(1'b1, s0);
    host.i2c_xfer(adr, 1'b0, CMD_RESET, 0, rd, ak);
    chk(24'(ak), 24'h1);
    chk(24'(sda_oe), 24'h0);
    host.i2c_xfer(adr | 7'h01, 1'b0, CMD_PROM_READ, 0, rd, ak);
    chk(24'(ak), 24'h0);
    host.i2c_xfer(adr, 1'b0, CMD_PROM_READ | 8'h06, 0, rd, ak);
    host.i2c_xfer(adr, 1'b1, 8'h00, 2, rd, ak);
    chk(rd, {8'h00, PROM_DEFAULT[64 +: 16]});
    host.i2c_xfer(adr, 1'b0, CMD_ADC_READ, 0, rd, ak);
    host.i2c_xfer(adr, 1'b1, 8'h00, 3, rd, ak);
    chk(rd, 24'h0);
    give_verdict();
  end
endmodule : tb_sensor_serial_command_port
